// ---- inc/protect_rx_pkg.sv ----
// package for the protection receiver status and key list register group
// assumes an apb slave with 32-bit data and byte addresses of four times the index
package protect_rx_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_DEBUG_CONTROL = 8'hc1;
  localparam logic [7:0] IDX_STATUS = 8'hc4;
  localparam logic [7:0] IDX_FIFO_DATA = 8'hc9;
  localparam logic [7:0] IDX_FIFO_ADDR_LOW = 8'hca;
  localparam logic [7:0] IDX_FIFO_ADDR_HIGH = 8'hcb;
  localparam logic [7:0] IDX_PORT0_INFO = 8'he0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd1;
  // field positions
  localparam int BIT_REENABLE_POLICY = 0;
  localparam int BIT_DECRYPT_BYPASS = 1;
  localparam int BIT_AUTHENTICATED = 0;
  localparam int BIT_CHECKSUM_ERROR = 1;
  // event bits of the interrupt status
  localparam int EV_CHECKSUM = 0;
  localparam int EV_AUTH_DONE = 1;
  localparam int EV_AUTH_LOST = 2;
  localparam int EV_WIDTH = 3;
  // reset values, key address width and channel count
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [8:0] RST_FIFO_ADDR = 9'h000;
  localparam int FIFO_ADDR_W = 9;
  localparam int CHANNELS = 3;

  // one received colour sample with its line end marker
  typedef struct packed {
    logic valid;
    logic [23:0] pixel;
    logic lineEnd;
  } pixel_beat_t;

  // checksums following a line end, one per 8-bit channel
  typedef struct packed {
    logic valid;
    logic [23:0] sums;
  } line_sum_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS} apb_state_t;

  // ones-complement 8-bit add with end-around carry
  function automatic logic [7:0] ones_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    ones_add = s[7:0] + {7'h00, s[8]};
  endfunction
endpackage

// ---- test/content_protect_rx_status_tb.sv ----
// self-checking bench for the protection status and key list registers
// assumes the apb slave answers with pready and the partner model drives video
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module content_protect_rx_status_tb;
  import protect_rx_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err, decryptBypass, repeater_reenable_policy, irq;
  logic line_checksum_enable = 1'b0, tx_port0_present = 1'b0;
  logic [6:0] tx_port0_bus_address = 7'h00;
  logic [8:0] keyReadAddr = 9'h000;
  logic [7:0] keyReadData;
  logic authDone, authLost, authRestart;
  pixel_beat_t cipherBeat, plainBeat, pixelOut;
  line_sum_t lineSum;
  int n_fail = 0, checked = 0;

  always #4 clk_sys = ~clk_sys;

  pixel_source_model src_u (.clk_sys(clk_sys), .cipherBeat(cipherBeat),
    .plainBeat(plainBeat), .lineSum(lineSum), .authDone(authDone),
    .authLost(authLost), .authRestart(authRestart));
  content_protect_rx_status dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cipherBeat(cipherBeat), .plainBeat(plainBeat), .lineSum(lineSum),
    .line_checksum_enable(line_checksum_enable), .authDone(authDone),
    .authLost(authLost), .authRestart(authRestart),
    .tx_port0_bus_address(tx_port0_bus_address), .tx_port0_present(tx_port0_present),
    .keyReadAddr(keyReadAddr), .keyReadData(keyReadData), .pixelOut(pixelOut),
    .decryptBypass(decryptBypass), .repeater_reenable_policy(repeater_reenable_policy),
    .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; the request stands until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) n_fail++;
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk_rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rdata, {24'h0, exp}, "read data")
  endtask

  // irq is registered, so let it settle before looking
  task chk_irq(input logic exp);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, exp, "irq level")
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_fail++;
    close_out;
  end

  // main sequence
  initial begin
    logic [7:0] idxs [8];
    idxs = '{IDX_DEBUG_CONTROL, IDX_STATUS, IDX_FIFO_DATA, IDX_FIFO_ADDR_LOW,
      IDX_FIFO_ADDR_HIGH, IDX_PORT0_INFO, IDX_IRQ_MASK, IDX_IRQ_STATUS};
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (idxs[i]) chk_rd(idxs[i], 8'h00);
    // bypass and policy bits, reserved bits dropped
    apb(1'b1, 8'hc1, 8'hff);
    chk_rd(8'hc1, 8'h03);
    `CHK({decryptBypass, repeater_reenable_policy}, 2'b11, "debug bits")
    `CHK(pixelOut, cipherBeat, "bypass pixels")
    apb(1'b1, 8'hc1, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK(pixelOut, plainBeat, "plain pixels")
    `CHK(repeater_reenable_policy, 1'b0, "policy off")
    // a write without the low byte lane is ignored
    pstrb <= 4'he;
    apb(1'b1, 8'hc1, 8'hff);
    pstrb <= 4'hf;
    chk_rd(8'hc1, 8'h00);
    // port0 info is read only; a write of ones must not stick
    for (int a = 0; a < 128; a += 37) begin
      tx_port0_bus_address <= 7'(a);
      tx_port0_present <= a[0];
      apb(1'b1, 8'he0, 8'hff);
      chk_rd(8'he0, {7'(a), a[0]});
    end
    // authentication flag with its events
    apb(1'b1, 8'hd0, 8'h07);
    src_u.pulse(0);
    chk_rd(8'hc4, 8'h01);
    // protected video only once the flag reads as set
    src_u.send_line(1'b0);
    chk_irq(1'b1);
    chk_rd(8'hd1, 8'h02);
    chk_irq(1'b0);
    src_u.pulse(1);
    chk_rd(8'hc4, 8'h00);
    src_u.pulse(0);
    src_u.pulse(2);
    chk_rd(8'hc4, 8'h00);
    chk_rd(8'hd1, 8'h06);
    // line checksums: good, bad, cleared by any write, ignored when off
    line_checksum_enable <= !line_checksum_enable; // now on
    src_u.send_line(1'b0);
    chk_rd(8'hc4, 8'h00);
    src_u.send_line(1'b1);
    chk_rd(8'hc4, 8'h02);
    chk_irq(1'b1);
    chk_rd(8'hd1, 8'h01);
    apb(1'b1, 8'hc4, 8'h5a);
    chk_rd(8'hc4, 8'h00);
    line_checksum_enable <= !line_checksum_enable; // now off
    src_u.send_line(1'b1);
    chk_rd(8'hc4, 8'h00);
    // key list from address zero, one byte
    apb(1'b1, 8'hca, 8'h00);
    apb(1'b1, 8'hcb, 8'h00);
    apb(1'b1, 8'hc9, 8'h96);
    chk_rd(8'hc9, 8'h96);
    chk_rd(8'hca, 8'h01);
    // the byte sits one below the address just read back
    keyReadAddr <= 9'(rdata) - 9'h001;
    repeat (3) @(posedge clk_sys);
    `CHK(keyReadData, 8'h96, "key byte 000")
    // key list across the low byte boundary
    apb(1'b1, 8'hca, 8'hff);
    apb(1'b1, 8'hcb, 8'h00);
    apb(1'b1, 8'hc9, 8'ha5);
    apb(1'b1, 8'hc9, 8'h3c);
    chk_rd(8'hca, 8'h01);
    chk_rd(8'hcb, 8'h01);
    keyReadAddr <= 9'h0ff;
    repeat (3) @(posedge clk_sys);
    `CHK(keyReadData, 8'ha5, "key byte 0ff")
    keyReadAddr <= 9'h100;
    repeat (3) @(posedge clk_sys);
    `CHK(keyReadData, 8'h3c, "key byte 100")
    // reset in mid-run brings control outputs and key address back to zero
    apb(1'b1, 8'hc1, 8'h03);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    `CHK({decryptBypass, repeater_reenable_policy}, 2'b00, "outputs after reset")
    chk_rd(8'hcb, 8'h00);
    // unmapped place answers with an error and zero
    apb(1'b0, 8'h00, 8'h00);
    `CHK({err, rdata}, 33'h100000000, "unmapped read")
    close_out;
  end
endmodule

// ---- test/pixel_source_model.sv ----
// partner model: cipher engine and link decoder feeding the status block
// assumes the bench calls its tasks and that all drive is on rising edges
`timescale 1ns/1ps
module pixel_source_model
  import protect_rx_pkg::*;
(
  input wire logic clk_sys,
  output pixel_beat_t cipherBeat,
  output pixel_beat_t plainBeat,
  output line_sum_t lineSum,
  output logic authDone,
  output logic authLost,
  output logic authRestart
);
  localparam pixel_beat_t PLAIN_IDLE = '{1'b0, 24'h123456, 1'b0};
  localparam pixel_beat_t CIPHER_IDLE = '{1'b0, 24'hedcba9, 1'b0};

  // own end-around carry add, kept apart from the design's helper
  function automatic logic [7:0] oadd(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction

  initial begin
    plainBeat = PLAIN_IDLE;
    cipherBeat = CIPHER_IDLE;
    lineSum = '0;
    {authDone, authLost, authRestart} = 3'h0;
  end

  // one line of four pixels, then its per-channel checksum; bad flips one bit
  task send_line(input logic bad);
    logic [23:0] s;
    logic [23:0] p;
    s = 24'h0;
    for (int i = 0; i < 4; i++) begin
      p = 24'hf0e0d0 + 24'h010203 * 24'(i);
      for (int c = 0; c < 3; c++) s[c*8 +: 8] = oadd(s[c*8 +: 8], p[c*8 +: 8]);
      @(posedge clk_sys);
      plainBeat <= '{1'b1, p, i == 3};
      cipherBeat <= '{1'b1, ~p, i == 3};
    end
    @(posedge clk_sys);
    plainBeat <= PLAIN_IDLE;
    cipherBeat <= CIPHER_IDLE;
    lineSum <= '{1'b1, ~s ^ {23'h0, bad}};
    @(posedge clk_sys);
    // stale sums are inverted so a late sample cannot pass by luck
    lineSum <= '{1'b0, s ^ {23'h0, bad}};
  endtask

  // one-cycle pulse: 0 done, 1 lost, 2 restart
  task pulse(input int k);
    @(posedge clk_sys);
    {authRestart, authLost, authDone} <= 3'h1 << k;
    @(posedge clk_sys);
    {authRestart, authLost, authDone} <= 3'h0;
  endtask
endmodule

// ---- verilog/content_protect_rx_status.sv ----
// Notes on behaviour
// RULE_01: bypass bit set passes encrypted pixels out
// RULE_02: policy bit selects protection re-enable behaviour
// RULE_03: checksum mismatch sets error flag when enabled
// RULE_04: any status write clears checksum error
// RULE_05: authenticated flag sets on successful authentication
// RULE_06: flag clears on auth loss or restart
// RULE_07: controller sends protected video after authentication
// RULE_08: controller loads key list through data register
// RULE_09: data byte stored at current key address
// RULE_10: key address increments after each data write
// RULE_11: controller zeroes key address before first byte
// RULE_12: low register holds address bits 7-0
// RULE_13: high register holds address bit 8
// RULE_14: port0 register bits 7-1 give bus address
// RULE_15: port0 bit 0 shows port present
// RULE_16: per-channel ones-complement line checksum compared
// RULE_17: reserved bits read zero, writes ignored
//
// holds the protection receiver debug, status, key list and port0 registers
// assumes cipher engine, link decoder and repeater logic around it
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module content_protect_rx_status
  import protect_rx_pkg::*;
#(
  parameter int KEY_DEPTH = 512
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pixel_beat_t cipherBeat,
  input wire pixel_beat_t plainBeat,
  input wire line_sum_t lineSum,
  input wire logic line_checksum_enable,
  input wire logic authDone,
  input wire logic authLost,
  input wire logic authRestart,
  input wire logic [6:0] tx_port0_bus_address,
  input wire logic tx_port0_present,
  input wire logic [FIFO_ADDR_W-1:0] keyReadAddr,
  output logic [7:0] keyReadData,
  output pixel_beat_t pixelOut,
  output logic decryptBypass,
  output logic repeater_reenable_policy,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // apb access decode
  apb_state_t apbState_q, apbState_d;
  logic [7:0] regIdx;
  logic idxAligned;
  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic mapped;

  assign regIdx = paddr[9:2];
  assign idxAligned = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  // zero wait states: access completes in the first access cycle
  assign acc = psel && penable && (apbState_q == ST_ACCESS);
  assign wrAcc = acc && pwrite;
  assign rdAcc = acc && !pwrite;

  // address decode for the mapped words
  always_comb begin
    mapped = 1'b0;
    if (idxAligned) begin
      case (regIdx)
        IDX_DEBUG_CONTROL, IDX_STATUS, IDX_FIFO_DATA, IDX_FIFO_ADDR_LOW,
        IDX_FIFO_ADDR_HIGH, IDX_PORT0_INFO, IDX_IRQ_MASK, IDX_IRQ_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // setup then access phase tracking
  always_comb begin
    apbState_d = apbState_q;
    case (apbState_q)
      ST_IDLE: begin
        if (psel && !penable) begin
          apbState_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (psel && !penable) begin
          apbState_d = ST_ACCESS;
        end else if (!(psel && penable)) begin
          apbState_d = ST_IDLE;
        end else begin
          apbState_d = ST_IDLE;
        end
      end
      default: apbState_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      apbState_q <= ST_IDLE;
    end else begin
      apbState_q <= apbState_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, status and key address registers
  logic [1:0] debugCtl_q, debugCtl_d;
  logic authenticated_flag_q, authenticated_flag_d;
  logic line_checksum_error_flag_q, line_checksum_error_flag_d;
  logic [FIFO_ADDR_W-1:0] keyAddr_q, keyAddr_d;
  logic [7:0] keyData_q, keyData_d;
  logic [EV_WIDTH-1:0] irqMask_q, irqMask_d;
  logic [EV_WIDTH-1:0] irqStat_q, irqStat_d;
  logic checksumMismatch;
  logic byteWr;
  logic [EV_WIDTH-1:0] events;

  assign byteWr = wrAcc && pstrb[0];
  assign events = {authLost && authenticated_flag_q, authDone && !authenticated_flag_q,
                   checksumMismatch};

  always_comb begin
    debugCtl_d = debugCtl_q;
    authenticated_flag_d = authenticated_flag_q;
    line_checksum_error_flag_d = line_checksum_error_flag_q;
    keyAddr_d = keyAddr_q;
    keyData_d = keyData_q;
    irqMask_d = irqMask_q;
    irqStat_d = irqStat_q;
    if (byteWr && mapped) begin
      case (regIdx)
        // upper bits are reserved and not stored
        IDX_DEBUG_CONTROL: debugCtl_d = pwdata[1:0]; // RULE_17
        IDX_FIFO_DATA: begin
          keyData_d = pwdata[7:0];
          keyAddr_d = keyAddr_q + 9'h001; // RULE_10
        end
        IDX_FIFO_ADDR_LOW: keyAddr_d[7:0] = pwdata[7:0]; // RULE_12
        IDX_FIFO_ADDR_HIGH: keyAddr_d[8] = pwdata[0]; // RULE_13
        IDX_IRQ_MASK: irqMask_d = pwdata[EV_WIDTH-1:0];
        default: ;
      endcase
    end
    // any write to status clears the error; a new mismatch wins
    if (wrAcc && mapped && regIdx == IDX_STATUS) begin
      line_checksum_error_flag_d = 1'b0; // RULE_04
    end
    if (checksumMismatch) begin
      line_checksum_error_flag_d = 1'b1; // RULE_03
    end
    // loss or restart dominates a completion in the same cycle
    if (authDone) begin
      authenticated_flag_d = 1'b1; // RULE_05
    end
    if (authLost || authRestart) begin
      authenticated_flag_d = 1'b0; // RULE_06
    end
    // read of the event status clears only the bits it returned, so an
    // event landing in the setup cycle is kept; new events win
    if (rdAcc && mapped && regIdx == IDX_IRQ_STATUS) begin
      irqStat_d = irqStat_q & ~prdata[EV_WIDTH-1:0];
    end
    irqStat_d = irqStat_d | events;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      debugCtl_q <= 2'h0;
      authenticated_flag_q <= 1'b0;
      line_checksum_error_flag_q <= 1'b0;
      keyAddr_q <= RST_FIFO_ADDR;
      keyData_q <= RST_REG;
      irqMask_q <= '0;
      irqStat_q <= '0;
    end else begin
      debugCtl_q <= debugCtl_d;
      authenticated_flag_q <= authenticated_flag_d;
      line_checksum_error_flag_q <= line_checksum_error_flag_d;
      keyAddr_q <= keyAddr_d;
      keyData_q <= keyData_d;
      irqMask_q <= irqMask_d;
      irqStat_q <= irqStat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key selection vector list storage, no reset on the array
  logic [7:0] keyMem [KEY_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (byteWr && mapped && regIdx == IDX_FIFO_DATA) begin
      keyMem[keyAddr_q] <= pwdata[7:0]; // RULE_09
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      keyReadData <= RST_REG;
    end else begin
      keyReadData <= keyMem[keyReadAddr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // running per-channel line checksum over received pixels
  logic [23:0] runSum_q, runSum_d;

  // sum restarts on each valid trailing checksum, which is compared to the complement of the sum so far
  always_comb begin
    runSum_d = runSum_q;
    checksumMismatch = 1'b0;
    if (plainBeat.valid) begin
      for (int c = 0; c < CHANNELS; c++) begin
        runSum_d[c*8 +: 8] = ones_add(runSum_q[c*8 +: 8], plainBeat.pixel[c*8 +: 8]);
      end
    end
    if (lineSum.valid) begin
      checksumMismatch = line_checksum_enable && (lineSum.sums != ~runSum_q); // RULE_16
      runSum_d = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      runSum_q <= '0;
    end else begin
      runSum_q <= runSum_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel output select and registered control outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pixelOut <= '0;
      decryptBypass <= 1'b0;
      repeater_reenable_policy <= 1'b0;
      irq <= 1'b0;
    end else begin
      // only the pixel path changes; the checksum keeps using plain data
      pixelOut <= debugCtl_d[BIT_DECRYPT_BYPASS] ? cipherBeat : plainBeat; // RULE_01
      decryptBypass <= debugCtl_d[BIT_DECRYPT_BYPASS]; // RULE_01
      repeater_reenable_policy <= debugCtl_d[BIT_REENABLE_POLICY]; // RULE_02
      irq <= |(irqStat_d & irqMask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux, registered during setup so it stands in access phase
  logic [7:0] rdByte;

  always_comb begin
    rdByte = 8'h00;
    case (regIdx)
      IDX_DEBUG_CONTROL: rdByte = {6'h00, debugCtl_q}; // RULE_17
      IDX_STATUS: rdByte = {6'h00, line_checksum_error_flag_q, authenticated_flag_q};
      IDX_FIFO_DATA: rdByte = keyData_q;
      IDX_FIFO_ADDR_LOW: rdByte = keyAddr_q[7:0]; // RULE_12
      IDX_FIFO_ADDR_HIGH: rdByte = {7'h00, keyAddr_q[8]}; // RULE_13
      IDX_PORT0_INFO: rdByte = {tx_port0_bus_address, tx_port0_present}; // RULE_14 RULE_15
      IDX_IRQ_MASK: rdByte = {5'h00, irqMask_q};
      IDX_IRQ_STATUS: rdByte = {5'h00, irqStat_q};
      default: rdByte = 8'h00;
    endcase
    if (!idxAligned) begin
      rdByte = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, rdByte} : 32'h00000000;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_key_addr_step: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_10
    (byteWr && mapped && regIdx == IDX_FIFO_DATA) |=> keyAddr_q == $past(keyAddr_q) + 9'h001)
    else $error("key address did not step after data write");
  chk_status_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_04
    (wrAcc && regIdx == IDX_STATUS && idxAligned && !checksumMismatch)
      |=> !line_checksum_error_flag_q)
    else $error("status write left checksum error set");
  chk_checksum_set: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
    checksumMismatch |=> line_checksum_error_flag_q)
    else $error("mismatch did not set checksum error");
  chk_auth_set: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_05
    (authDone && !authLost && !authRestart) |=> authenticated_flag_q)
    else $error("authenticated flag not set");
  chk_auth_clear: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_06
    (authLost || authRestart) |=> !authenticated_flag_q)
    else $error("authenticated flag not cleared");
  chk_bypass_pixels: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_01
    decryptBypass |-> pixelOut == $past(cipherBeat))
    else $error("bypass did not pass encrypted pixels");
  chk_policy_follow: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_02
    (byteWr && regIdx == IDX_DEBUG_CONTROL && idxAligned)
      |=> repeater_reenable_policy == $past(pwdata[0]))
    else $error("policy output does not follow written bit");
  chk_key_store: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_09
    (byteWr && mapped && regIdx == IDX_FIFO_DATA)
      |=> keyMem[$past(keyAddr_q)] == $past(pwdata[7:0]))
    else $error("key byte not stored at address");
  chk_port0_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_14 RULE_15
    (psel && !penable && !pwrite && paddr == {2'h0, IDX_PORT0_INFO, 2'h0})
      |=> prdata[7:0] == {$past(tx_port0_bus_address), $past(tx_port0_present)})
    else $error("port0 read data wrong");
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_17
    pready |-> prdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");
  chk_addr_high_bit: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_13
    (byteWr && regIdx == IDX_FIFO_ADDR_HIGH && idxAligned)
      |=> keyAddr_q[8] == $past(pwdata[0]) && keyAddr_q[7:0] == $past(keyAddr_q[7:0]))
    else $error("high address write wrong");

  // guards on paths the bench reaches only in passing
  chk_addr_low_write: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_12
    (byteWr && mapped && regIdx == IDX_FIFO_ADDR_LOW)
      |=> keyAddr_q[7:0] == $past(pwdata[7:0]) && keyAddr_q[8] == $past(keyAddr_q[8]))
    else $error("low address write wrong");
  chk_error_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_04
    (!checksumMismatch && !(wrAcc && mapped && regIdx == IDX_STATUS))
      |=> line_checksum_error_flag_q == $past(line_checksum_error_flag_q))
    else $error("checksum error changed with no cause");
  chk_checksum_gate: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
    !line_checksum_enable |-> !checksumMismatch)
    else $error("mismatch flagged with checksums off");
  chk_auth_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_05
    !(authDone || authLost || authRestart) |=> $stable(authenticated_flag_q))
    else $error("authenticated flag changed with no cause");
  chk_plain_pixels: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_01
    ($past(rstn) && !decryptBypass) |-> pixelOut == $past(plainBeat))
    else $error("plain pixels not passed");
  chk_debug_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_02
    !(byteWr && mapped && regIdx == IDX_DEBUG_CONTROL) |=> $stable(debugCtl_q))
    else $error("debug bits changed with no write");
  chk_read_status: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03 RULE_05
    (psel && !penable && !pwrite && mapped && regIdx == IDX_STATUS)
      |=> prdata == {30'h0, $past(line_checksum_error_flag_q), $past(authenticated_flag_q)})
    else $error("status read data wrong");
  chk_event_sticky: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03 RULE_05
    (|events) |=> (irqStat_q & $past(events)) == $past(events))
    else $error("event did not set its status bit");
  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq == |(irqStat_q & irqMask_q))
    else $error("interrupt level does not follow status and mask");
  chk_unmapped_err: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_17
    (psel && !penable && !mapped) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  chk_ready_once: assert property (@(posedge clk_sys) disable iff (!rstn)
    pready == $past(psel && !penable))
    else $error("ready not one cycle after setup");
  chk_strobe_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrAcc && !pstrb[0]) |=> $stable(keyAddr_q))
    else $error("write without low lane moved the key address");
endmodule
